// ---- rtl/ppmd_port_mux.sv ----
// pin multiplexing, direction and analog gating for rc5..rc7 and port d
//
// Behaviour
// RULE_01: direction 0 drives latch, analog ignored
// RULE_02: direction 1 reads pin; analog blocks input
// RULE_03: serial data out drives rc5 as output
// RULE_04: usart transmit drives rc6 despite direction 1
// RULE_05: usart clock out when master, else in
// RULE_06: usart sync data drives or samples rc7
// RULE_07: usart receiver samples rc7 digital input
// RULE_08: unit 3 compare out, capture in
// RULE_09: pwm3 outputs 1 and 2 drive rc6, rc7
// RULE_10: select bit set means default pin
// RULE_11: unimplemented register bits read zero
// RULE_12: fourth port eight bidirectional pins
// RULE_13: direction 1 turns output driver off
// RULE_14: direction 0 enables driver with latch
// RULE_15: latch register reads back latch, not pins
// RULE_16: reset makes fourth port analog inputs
// RULE_17: highest priority function owns the pin
// RULE_18: analog function active when select set
// RULE_19: digital outputs still drive in analog mode
// RULE_20: port write sets latch, read gives pins
`timescale 1ns/1ps
module ppmd_port_mux #(
   parameter int PD_WIDTH = 8
) (
   input wire logic SYS_CLK, // 40 mhz system clock
   input wire logic RSTN, // synchronous reset, active low
   input wire logic [ppmd_pkg::AW-1:0] ADDR, // register index
   input wire logic [ppmd_pkg::DW-1:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [ppmd_pkg::DW-1:0] RDATA, // read data, cycle after rd
   input wire logic [2:0] PC_IN, // rc7..rc5 pin levels
   output logic [2:0] PC_OUT, // rc7..rc5 pin drive value
   output logic [2:0] PC_OE, // rc7..rc5 driver enable
   input wire logic [PD_WIDTH-1:0] PD_IN, // fourth port pin levels
   output logic [PD_WIDTH-1:0] PD_OUT, // fourth port drive value
   output logic [PD_WIDTH-1:0] PD_OE, // fourth port driver enable
   input wire logic SDO_EN, // serial unit 1 data out active
   input wire logic SDO_OUT, // serial unit 1 data out
   input wire logic USART_EN, // usart serial port enabled
   input wire logic USART_SYNC, // usart in synchronous mode
   input wire logic USART_CK_MASTER, // usart sources the clock
   input wire logic USART_CK_OUT, // usart sync clock out
   input wire logic USART_TX_EN, // usart async transmit enabled
   input wire logic USART_TX_OUT, // usart async transmit data
   input wire logic USART_DT_DRIVE, // usart sync data transmitting
   input wire logic USART_DT_OUT, // usart sync data out
   input wire logic CC3_EN, // unit 3 compare or pwm active
   input wire logic CC3_OUT, // unit 3 compare or pwm out
   input wire logic PWM3_1_EN, // pwm3 output 1 active
   input wire logic PWM3_1_OUT, // pwm3 output 1
   input wire logic PWM3_2_EN, // pwm3 output 2 active
   input wire logic PWM3_2_OUT, // pwm3 output 2
   input wire logic PWM2B_EN, // pwm2 output 2 active
   input wire logic PWM2B_OUT, // pwm2 output 2
   output logic RX_IN, // usart receive input
   output logic CK_IN, // usart sync clock input
   output logic DT_IN, // usart sync data input
   output logic CC3_CAP_IN, // unit 3 capture input
   output logic [2:0] ANA_SEL_C, // analog enables rc7..rc5
   output logic [PD_WIDTH-1:0] ANA_SEL_D, // analog enables port d
   output logic [ppmd_pkg::SLEW_W-1:0] SLEW, // slew rate controls
   output logic PWM2B_SEL, // pwm2 output 2 on default pin
   output logic T3_SEL, // timer3 clock on default pin
   output logic CC3_SEL, // unit 3 on default pin
   output logic CC2_SEL // unit 2 on default pin
);

   // ****************************************
   // parameter check
   // ****************************************
   // the pwm2 default pin sits at bit 2, the bus is 8 bits wide
   if (PD_WIDTH < 3 || PD_WIDTH > ppmd_pkg::DW) begin : g_bad_width
      $error("PD_WIDTH must lie between 3 and 8");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [ppmd_pkg::DW-1:0] dir_c;
      logic [ppmd_pkg::DW-1:0] lat_c;
      logic [ppmd_pkg::DW-1:0] ans_c;
      logic [ppmd_pkg::DW-1:0] slew;
      logic [ppmd_pkg::DW-1:0] cfg;
      logic [PD_WIDTH-1:0] dir_d;
      logic [PD_WIDTH-1:0] lat_d;
      logic [PD_WIDTH-1:0] ans_d;
      logic [PD_WIDTH-1:0] pd_lvl;
      logic [PD_WIDTH-1:0] pd_out;
      logic [PD_WIDTH-1:0] pd_oe;
      logic [2:0] pc_lvl;
      logic [2:0] pc_out;
      logic [2:0] pc_oe;
      logic [ppmd_pkg::DW-1:0] rdata;
      logic rx_in;
      logic ck_in;
      logic dt_in;
      logic cc3_cap;
   } ppmd_state_s;

   ppmd_state_s s_r;
   ppmd_state_s s_nxt;
   logic [PD_WIDTH-1:0] pd_val;
   logic rc6_usart;
   logic rc7_usart;
   logic cc3_here;

   // ****************************************
   // fourth port drive values
   // ****************************************
   // rd2 is the default pin of pwm2 output 2: it owns rd2 only while its
   // select bit is set; with the bit clear it lives elsewhere
   for (genvar i = 0; i < PD_WIDTH; i++) begin : g_pd
      if (i == ppmd_pkg::PD_PWM2B_PIN) begin : g_pwm2b
         assign pd_val[i] = (PWM2B_EN && s_r.cfg[ppmd_pkg::CFG_PWM2B]) ?
            PWM2B_OUT : s_r.lat_d[i]; // see RULE_10 see RULE_17
      end else begin : g_lat
         assign pd_val[i] = s_r.lat_d[i]; // see RULE_12
      end
   end

   // usart pin ownership overrides the direction bits
   assign rc6_usart = USART_EN &&
      (USART_SYNC ? USART_CK_MASTER : USART_TX_EN); // see RULE_04
   assign rc7_usart = USART_EN && USART_SYNC && USART_DT_DRIVE;
   // rc6 is the alternate pin of unit 3, so it is used with the bit clear
   assign cc3_here = !s_r.cfg[ppmd_pkg::CFG_CC3]; // see RULE_10

   // ****************************************
   // next state
   // ****************************************
   // one process holds bus decode, port c pin mux and input gating
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = '0;
      // register writes; port data writes land in the latch
      if (WR) begin
         case (ADDR)
            ppmd_pkg::IDX_PIN_C: s_nxt.lat_c = WDATA; // see RULE_20
            ppmd_pkg::IDX_LAT_C: s_nxt.lat_c = WDATA; // see RULE_15
            ppmd_pkg::IDX_DIR_C: s_nxt.dir_c = WDATA;
            ppmd_pkg::IDX_ANS_C: s_nxt.ans_c = WDATA & ppmd_pkg::MASK_ANS_C;
            ppmd_pkg::IDX_SLEW: s_nxt.slew = WDATA & ppmd_pkg::MASK_SLEW;
            ppmd_pkg::IDX_PIN_D: s_nxt.lat_d = WDATA[PD_WIDTH-1:0];
            ppmd_pkg::IDX_LAT_D: s_nxt.lat_d = WDATA[PD_WIDTH-1:0];
            ppmd_pkg::IDX_DIR_D: s_nxt.dir_d = WDATA[PD_WIDTH-1:0];
            ppmd_pkg::IDX_ANS_D: s_nxt.ans_d = WDATA[PD_WIDTH-1:0];
            ppmd_pkg::IDX_CFG: s_nxt.cfg = WDATA & ppmd_pkg::MASK_CFG;
            default: ;
         endcase
      end
      // reads; unmapped indices and missing bits answer zero
      if (RD) begin
         case (ADDR)
            ppmd_pkg::IDX_PIN_C: s_nxt.rdata = {s_r.pc_lvl, 5'h00};
            ppmd_pkg::IDX_LAT_C: s_nxt.rdata = s_r.lat_c; // see RULE_15
            ppmd_pkg::IDX_DIR_C: s_nxt.rdata = s_r.dir_c;
            ppmd_pkg::IDX_ANS_C: s_nxt.rdata = s_r.ans_c; // see RULE_11
            ppmd_pkg::IDX_SLEW: s_nxt.rdata = s_r.slew;
            ppmd_pkg::IDX_PIN_D: s_nxt.rdata = 8'(s_r.pd_lvl); // see RULE_20
            ppmd_pkg::IDX_LAT_D: s_nxt.rdata = 8'(s_r.lat_d);
            ppmd_pkg::IDX_DIR_D: s_nxt.rdata = 8'(s_r.dir_d);
            ppmd_pkg::IDX_ANS_D: s_nxt.rdata = 8'(s_r.ans_d);
            ppmd_pkg::IDX_CFG: s_nxt.rdata = s_r.cfg;
            default: s_nxt.rdata = '0;
         endcase
      end
      // rc5: serial data out outranks the latch, driver from direction
      s_nxt.pc_oe[0] = !s_r.dir_c[ppmd_pkg::B_RC5]; // see RULE_13
      s_nxt.pc_out[0] = SDO_EN ? SDO_OUT :
         s_r.lat_c[ppmd_pkg::B_RC5]; // see RULE_03 see RULE_01
      // rc6: usart first, then pwm3 output 1, compare 3, latch
      if (rc6_usart) begin
         s_nxt.pc_oe[1] = 1'b1; // see RULE_05
         s_nxt.pc_out[1] = USART_SYNC ? USART_CK_OUT : USART_TX_OUT;
      end else begin
         s_nxt.pc_oe[1] = !s_r.dir_c[ppmd_pkg::B_RC6]; // see RULE_14
         if (PWM3_1_EN) begin
            s_nxt.pc_out[1] = PWM3_1_OUT; // see RULE_09
         end else if (CC3_EN && cc3_here) begin
            s_nxt.pc_out[1] = CC3_OUT; // see RULE_08 see RULE_17
         end else begin
            s_nxt.pc_out[1] = s_r.lat_c[ppmd_pkg::B_RC6];
         end
      end
      // rc7: usart sync data first, then pwm3 output 2, latch
      if (rc7_usart) begin
         s_nxt.pc_oe[2] = 1'b1; // see RULE_06
         s_nxt.pc_out[2] = USART_DT_OUT;
      end else begin
         s_nxt.pc_oe[2] = !s_r.dir_c[ppmd_pkg::B_RC7];
         s_nxt.pc_out[2] = PWM3_2_EN ? PWM3_2_OUT :
            s_r.lat_c[ppmd_pkg::B_RC7]; // see RULE_09
      end
      // analog selection gates the inputs only, never the drivers
      for (int i = 0; i < ppmd_pkg::PC_PINS; i++) begin
         s_nxt.pc_lvl[i] = PC_IN[i] &&
            !s_r.ans_c[ppmd_pkg::PC_BASE+i]; // see RULE_02 see RULE_19
      end
      s_nxt.pd_lvl = PD_IN & ~s_r.ans_d; // see RULE_02
      s_nxt.pd_out = pd_val;
      s_nxt.pd_oe = ~s_r.dir_d; // see RULE_12 see RULE_13 see RULE_14
      // peripheral inputs come from the gated digital levels
      s_nxt.rx_in = s_nxt.pc_lvl[2]; // see RULE_07
      s_nxt.dt_in = s_nxt.pc_lvl[2]; // see RULE_06
      s_nxt.ck_in = s_nxt.pc_lvl[1]; // see RULE_05
      // capture only listens while rc6 is an input and holds unit 3
      s_nxt.cc3_cap = cc3_here && s_r.dir_c[ppmd_pkg::B_RC6] &&
         s_nxt.pc_lvl[1]; // see RULE_08 see RULE_10
      // synchronous reset: all pins inputs, port d analog
      if (!RSTN) begin
         s_nxt = '0;
         s_nxt.dir_c = ppmd_pkg::RST_DIR;
         s_nxt.lat_c = ppmd_pkg::RST_LAT;
         s_nxt.ans_c = ppmd_pkg::RST_ANS & ppmd_pkg::MASK_ANS_C;
         s_nxt.slew = ppmd_pkg::RST_SLEW;
         s_nxt.cfg = ppmd_pkg::RST_CFG;
         s_nxt.dir_d = '1;
         s_nxt.lat_d = '0;
         s_nxt.ans_d = PD_WIDTH'(ppmd_pkg::RST_ANS); // see RULE_16
      end
   end

   // ****************************************
   // state register
   // ****************************************
   // every output below is a field of this one register
   always_ff @(posedge SYS_CLK) begin
      s_r <= s_nxt;
   end

   // ****************************************
   // outputs
   // ****************************************
   // analog enables feed the converter channel muxes
   assign RDATA = s_r.rdata;
   assign PC_OUT = s_r.pc_out;
   assign PC_OE = s_r.pc_oe;
   assign PD_OUT = s_r.pd_out;
   assign PD_OE = s_r.pd_oe;
   assign RX_IN = s_r.rx_in;
   assign CK_IN = s_r.ck_in;
   assign DT_IN = s_r.dt_in;
   assign CC3_CAP_IN = s_r.cc3_cap;
   assign ANA_SEL_C =
      s_r.ans_c[ppmd_pkg::B_RC7:ppmd_pkg::B_RC5]; // see RULE_18
   assign ANA_SEL_D = s_r.ans_d; // see RULE_18
   assign SLEW = s_r.slew[ppmd_pkg::SLEW_W-1:0];
   assign PWM2B_SEL = s_r.cfg[ppmd_pkg::CFG_PWM2B];
   assign T3_SEL = s_r.cfg[ppmd_pkg::CFG_T3]; // see RULE_10
   assign CC3_SEL = s_r.cfg[ppmd_pkg::CFG_CC3];
   assign CC2_SEL = s_r.cfg[ppmd_pkg::CFG_CC2]; // see RULE_10

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   property p_rc5_latch;
      !s_r.dir_c[ppmd_pkg::B_RC5] && !SDO_EN |=>
         PC_OE[0] && PC_OUT[0] == $past(s_r.lat_c[ppmd_pkg::B_RC5]);
   endproperty
   a_rc5_latch: assert property (p_rc5_latch) // see RULE_01
      else $error("rc5 does not show its latch");

   property p_rc5_sdo;
      !s_r.dir_c[ppmd_pkg::B_RC5] && SDO_EN |=>
         PC_OE[0] && PC_OUT[0] == $past(SDO_OUT);
   endproperty
   a_rc5_sdo: assert property (p_rc5_sdo) // see RULE_03
      else $error("serial data out not on rc5");

   property p_ans_gate;
      s_r.ans_c[ppmd_pkg::B_RC7] |=> !s_r.pc_lvl[2] && !RX_IN;
   endproperty
   a_ans_gate: assert property (p_ans_gate) // see RULE_02
      else $error("analog rc7 still reads digital");

   sequence s_rd_pc;
      RD && ADDR == ppmd_pkg::IDX_PIN_C;
   endsequence
   property p_port_read;
      s_rd_pc |=> RDATA == {$past(s_r.pc_lvl), 5'h00};
   endproperty
   a_port_read: assert property (p_port_read) // see RULE_20
      else $error("port c read is not the pin levels");

   property p_tx;
      USART_EN && !USART_SYNC && USART_TX_EN |=>
         PC_OE[1] && PC_OUT[1] == $past(USART_TX_OUT);
   endproperty
   a_tx: assert property (p_tx) // see RULE_04
      else $error("usart transmit not driving rc6");

   property p_ck_in;
      USART_EN && USART_SYNC && !USART_CK_MASTER &&
         s_r.dir_c[ppmd_pkg::B_RC6] |=> !PC_OE[1];
   endproperty
   a_ck_in: assert property (p_ck_in) // see RULE_05
      else $error("rc6 driven while usart clock is input");

   property p_dt;
      USART_EN && USART_SYNC && USART_DT_DRIVE |=>
         PC_OE[2] && PC_OUT[2] == $past(USART_DT_OUT);
   endproperty
   a_dt: assert property (p_dt) // see RULE_06
      else $error("usart sync data not driving rc7");

   property p_cc3_cap;
      cc3_here && s_r.dir_c[ppmd_pkg::B_RC6] &&
         !s_r.ans_c[ppmd_pkg::B_RC6] |=> CC3_CAP_IN == $past(PC_IN[1]);
   endproperty
   a_cc3_cap: assert property (p_cc3_cap) // see RULE_08
      else $error("capture 3 input not following rc6");

   property p_pwm3b;
      !rc7_usart && !s_r.dir_c[ppmd_pkg::B_RC7] && PWM3_2_EN |=>
         PC_OE[2] && PC_OUT[2] == $past(PWM3_2_OUT);
   endproperty
   a_pwm3b: assert property (p_pwm3b) // see RULE_09
      else $error("pwm3 output 2 not on rc7");

   property p_cc3_out;
      cc3_here && CC3_EN && !rc6_usart && !PWM3_1_EN &&
         !s_r.dir_c[ppmd_pkg::B_RC6] |=>
         PC_OE[1] && PC_OUT[1] == $past(CC3_OUT);
   endproperty
   a_cc3_out: assert property (p_cc3_out) // see RULE_08
      else $error("compare 3 output not on rc6");

   property p_pwm2b;
      s_r.cfg[ppmd_pkg::CFG_PWM2B] && PWM2B_EN &&
         !s_r.dir_d[ppmd_pkg::PD_PWM2B_PIN] |=>
         PD_OUT[ppmd_pkg::PD_PWM2B_PIN] == $past(PWM2B_OUT);
   endproperty
   a_pwm2b: assert property (p_pwm2b) // see RULE_10
      else $error("pwm2 output 2 not on its default pin");

   // with the select bit clear rd2 must show its latch, whatever pwm2 does
   property p_pwm2b_alt;
      !s_r.cfg[ppmd_pkg::CFG_PWM2B] |=>
         PD_OUT[ppmd_pkg::PD_PWM2B_PIN] ==
         $past(s_r.lat_d[ppmd_pkg::PD_PWM2B_PIN]);
   endproperty
   a_pwm2b_alt: assert property (p_pwm2b_alt) // see RULE_10
      else $error("pwm2 output 2 on rd2 while relocated");

   property p_unimp;
      RD && ADDR == ppmd_pkg::IDX_ANS_C |=> RDATA[1:0] == 2'h0;
   endproperty
   a_unimp: assert property (p_unimp) // see RULE_11
      else $error("unimplemented analog bits read nonzero");

   sequence s_wr_then_rd_lat;
      WR && ADDR == ppmd_pkg::IDX_LAT_D ##1
         RD && ADDR == ppmd_pkg::IDX_LAT_D;
   endsequence
   property p_lat_rmw;
      s_wr_then_rd_lat |=>
         RDATA == 8'($past(WDATA[PD_WIDTH-1:0], 2));
   endproperty
   a_lat_rmw: assert property (p_lat_rmw) // see RULE_15
      else $error("latch d read does not return written value");

   property p_por;
      disable iff (1'b0)
      !RSTN |=> PD_OE == '0 && ANA_SEL_D == '1;
   endproperty
   a_por: assert property (p_por) // see RULE_16
      else $error("port d not analog input after reset");

endmodule

// ---- rtl/ppmd_pkg.sv ----
// constants for the upper port c pins and the fourth port pin logic
package ppmd_pkg;

   // ****************************************
   // register bus geometry
   // ****************************************
   localparam int AW = 4;
   localparam int DW = 8;

   // ****************************************
   // register indices
   // ****************************************
   localparam logic [AW-1:0] IDX_PIN_C = 4'h0;
   localparam logic [AW-1:0] IDX_LAT_C = 4'h1;
   localparam logic [AW-1:0] IDX_DIR_C = 4'h2;
   localparam logic [AW-1:0] IDX_ANS_C = 4'h3;
   localparam logic [AW-1:0] IDX_SLEW = 4'h4;
   localparam logic [AW-1:0] IDX_PIN_D = 4'h5;
   localparam logic [AW-1:0] IDX_LAT_D = 4'h6;
   localparam logic [AW-1:0] IDX_DIR_D = 4'h7;
   localparam logic [AW-1:0] IDX_ANS_D = 4'h8;
   localparam logic [AW-1:0] IDX_CFG = 4'h9;

   // ****************************************
   // reset values and implemented-bit masks
   // ****************************************
   localparam logic [DW-1:0] RST_DIR = 8'hff;
   localparam logic [DW-1:0] RST_LAT = 8'h00;
   localparam logic [DW-1:0] RST_ANS = 8'hff;
   localparam logic [DW-1:0] RST_SLEW = 8'h00;
   localparam logic [DW-1:0] RST_CFG = 8'h35;
   localparam logic [DW-1:0] MASK_ANS_C = 8'hfc;
   localparam logic [DW-1:0] MASK_SLEW = 8'h1f;
   localparam logic [DW-1:0] MASK_CFG = 8'h35;

   // ****************************************
   // field positions
   // ****************************************
   localparam int PC_PINS = 3;
   localparam int PC_BASE = 5;
   localparam int B_RC5 = 5;
   localparam int B_RC6 = 6;
   localparam int B_RC7 = 7;
   localparam int CFG_PWM2B = 5;
   localparam int CFG_T3 = 4;
   localparam int CFG_CC3 = 2;
   localparam int CFG_CC2 = 0;
   localparam int PD_PWM2B_PIN = 2;
   localparam int SLEW_W = 5;

endpackage

// ---- tb/ppmd_pin_model.sv ----
// pad model: resolves each pin from the device driver and an outside source
`timescale 1ns/1ps
module ppmd_pin_model #(
   parameter int W = 3
) (
   input wire logic [W-1:0] oe, // device driver enable
   input wire logic [W-1:0] dout, // device drive value
   input wire logic [W-1:0] ext, // outside source level
   output logic [W-1:0] pin // resolved pad level
);
   // outside source yields wherever the device drives, so no contention
   assign pin = (oe & dout) | (~oe & ext);
endmodule

// ---- tb/ppmd_port_mux_tb.sv ----
// self-checking bench for the upper port c pins and fourth port logic
`timescale 1ns/1ps
module ppmd_port_mux_tb;
   logic sys_clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, pd_in, pd_out, pd_oe, ana_d;
   logic [7:0] ext_d = 8'h00;
   logic [2:0] ext_c = 3'h0, pc_in, pc_out, pc_oe, ana_c;
   logic sdo_en = 1'b0, sdo_out = 1'b0, u_en = 1'b0, u_sync = 1'b0;
   logic u_ckm = 1'b0, u_cko = 1'b0, u_txe = 1'b0, u_txo = 1'b0;
   logic u_dtd = 1'b0, u_dto = 1'b0, cc3_en = 1'b0, cc3_out = 1'b0;
   logic pwm31_en = 1'b0, pwm31_out = 1'b0;
   logic pwm32_en = 1'b0, pwm32_out = 1'b0;
   logic pwm2b_en = 1'b0, pwm2b_out = 1'b0;
   logic rx_in, ck_in, dt_in, cap_in, s_pwm2b, s_t3, s_cc3, s_cc2;
   logic [4:0] slew;
   int num_errors = 0, cmp_count = 0, cycles = 0;
   // expected reads right after reset, indices 0..9
   logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'hff, 8'hfc, 8'h00,
                                8'h00, 8'h00, 8'hff, 8'hff, 8'h35};

   ppmd_pin_model #(.W(3)) i_pc (.oe(pc_oe), .dout(pc_out), .ext(ext_c),
      .pin(pc_in));
   ppmd_pin_model #(.W(8)) i_pd (.oe(pd_oe), .dout(pd_out), .ext(ext_d),
      .pin(pd_in));
   ppmd_port_mux #(.PD_WIDTH(8)) i_dut (.SYS_CLK(sys_clk), .RSTN(rstn),
      .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe), .PD_IN(pd_in),
      .PD_OUT(pd_out), .PD_OE(pd_oe), .SDO_EN(sdo_en), .SDO_OUT(sdo_out),
      .USART_EN(u_en), .USART_SYNC(u_sync), .USART_CK_MASTER(u_ckm),
      .USART_CK_OUT(u_cko), .USART_TX_EN(u_txe), .USART_TX_OUT(u_txo),
      .USART_DT_DRIVE(u_dtd), .USART_DT_OUT(u_dto), .CC3_EN(cc3_en),
      .CC3_OUT(cc3_out), .PWM3_1_EN(pwm31_en), .PWM3_1_OUT(pwm31_out),
      .PWM3_2_EN(pwm32_en), .PWM3_2_OUT(pwm32_out), .PWM2B_EN(pwm2b_en),
      .PWM2B_OUT(pwm2b_out), .RX_IN(rx_in), .CK_IN(ck_in), .DT_IN(dt_in),
      .CC3_CAP_IN(cap_in), .ANA_SEL_C(ana_c), .ANA_SEL_D(ana_d),
      .SLEW(slew), .PWM2B_SEL(s_pwm2b), .T3_SEL(s_t3), .CC3_SEL(s_cc3),
      .CC2_SEL(s_cc2));

   // ****************************************
   // clock, timeout and verdict
   // ****************************************
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // under two hundred cycles are needed; the ceiling leaves ample margin
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // strobes are released one edge later, so back-to-back calls never clash
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask

   // register to driver to pad to sampled input takes up to three edges
   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset state of every register and of the port d drivers
      for (int i = 0; i < 10; i++) begin
         rd(4'(i), rst_tab[i]);
      end
      chk("pd_oe", 8'h00, pd_oe);
      chk("ana_d", 8'hff, ana_d);
      chk("sel", 8'h0f, {4'h0, s_pwm2b, s_t3, s_cc3, s_cc2});
      // unimplemented bits and an unmapped index
      wr(4'h3, 8'hff);
      rd(4'h3, 8'hfc);
      wr(4'h4, 8'hff);
      rd(4'h4, 8'h1f);
      wr(4'ha, 8'h55);
      rd(4'ha, 8'h00);
      chk("slew", 8'h1f, {3'h0, slew});
      wr(4'h9, 8'h00);
      rd(4'h9, 8'h00);
      chk("sel", 8'h00, {4'h0, s_pwm2b, s_t3, s_cc3, s_cc2});
      // fourth port: direction, latch and gated reads
      @(posedge sys_clk);
      ext_d <= 8'h3c;
      wr(4'h7, 8'h0f);
      wr(4'h8, 8'h00);
      wr(4'h5, 8'ha5);
      settle();
      chk("pd_oe", 8'hf0, pd_oe);
      chk("pd_drv", 8'ha0, pd_out & pd_oe);
      rd(4'h6, 8'ha5);
      rd(4'h5, 8'hac);
      wr(4'h8, 8'h0f);
      settle();
      rd(4'h5, 8'ha0);
      chk("pd_drv", 8'ha0, pd_out & pd_oe);
      chk("ana_d", 8'h0f, ana_d);
      // pwm2 output 2 reaches rd2, its default pin, only with select set
      wr(4'h7, 8'h0b);
      @(posedge sys_clk);
      pwm2b_en <= 1'b1;
      settle();
      chk("rd2", 8'h03, {6'h0, pd_oe[2], pd_out[2]});
      wr(4'h9, 8'h35);
      settle();
      chk("rd2", 8'h02, {6'h0, pd_oe[2], pd_out[2]});
      // upper port c pins: latch drive, analog gating, input sampling
      @(posedge sys_clk);
      ext_c <= 3'b010;
      wr(4'h0, 8'ha0);
      wr(4'h2, 8'h1f);
      settle();
      chk("pc", 8'h3d, {2'h0, pc_oe, pc_out});
      rd(4'h0, 8'h00);
      rd(4'h1, 8'ha0);
      wr(4'h3, 8'h00);
      settle();
      rd(4'h0, 8'ha0);
      wr(4'h2, 8'hff);
      settle();
      chk("pc_oe", 8'h00, {5'h0, pc_oe});
      rd(4'h0, 8'h40);
      chk("ins", 8'h04, {4'h0, rx_in, ck_in, dt_in, cap_in});
      // unit 3 moves to rc6, its alternate pin, once its select bit clears
      wr(4'h9, 8'h31);
      settle();
      chk("ins", 8'h05, {4'h0, rx_in, ck_in, dt_in, cap_in});
      @(posedge sys_clk);
      ext_c <= 3'b101;
      settle();
      chk("ins", 8'h0a, {4'h0, rx_in, ck_in, dt_in, cap_in});
      // usart pins drive although their direction bits are 1
      @(posedge sys_clk);
      u_en <= 1'b1;
      u_txe <= 1'b1;
      u_txo <= 1'b1;
      settle();
      chk("tx", 8'h03, {6'h0, pc_oe[1], pc_out[1]});
      @(posedge sys_clk);
      u_txe <= 1'b0;
      u_sync <= 1'b1;
      u_ckm <= 1'b1;
      u_cko <= 1'b1;
      u_dtd <= 1'b1;
      settle();
      chk("pc", 8'h33, {2'h0, pc_oe, pc_out});
      @(posedge sys_clk);
      u_ckm <= 1'b0;
      u_dtd <= 1'b0;
      settle();
      chk("pc_oe", 8'h00, {5'h0, pc_oe});
      // output peripherals under direction 0 and their priority
      @(posedge sys_clk);
      u_en <= 1'b0;
      u_sync <= 1'b0;
      cc3_en <= 1'b1;
      cc3_out <= 1'b1;
      sdo_en <= 1'b1;
      wr(4'h2, 8'h1f);
      settle();
      chk("pc", 8'h3e, {2'h0, pc_oe, pc_out});
      @(posedge sys_clk);
      pwm31_en <= 1'b1;
      pwm32_en <= 1'b1;
      settle();
      chk("pc", 8'h38, {2'h0, pc_oe, pc_out});
      wr(4'h3, 8'he0);
      settle();
      chk("pc", 8'h38, {2'h0, pc_oe, pc_out});
      chk("ana_c", 8'h07, {5'h0, ana_c});
      // latch d written and read back in adjacent cycles, no gap
      @(posedge sys_clk);
      addr <= 4'h6;
      wdata <= 8'h3c;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1;
      chk("lat_d", 8'h3c, rdata);
      // let the read-back assertion reach its checking edge
      repeat (2) @(posedge sys_clk);
      give_verdict();
   end
endmodule
